// ---- offset_combiner_map.vh ----
// Register offsets, field positions, reset values and timing counts for the phase offset combiner.
`ifndef OFFSET_COMBINER_MAP_VH
`define OFFSET_COMBINER_MAP_VH
`define OC_ADDR_W 12
`define OC_IN_OFFS_BASE 12'h000
`define OC_CH_OFFS_BASE 12'h040
`define OC_CH_CTRL_BASE 12'h080
`define OC_CH_FREQ_BASE 12'h0c0
`define OC_CH_LFIN_BASE 12'h100
`define OC_CH_STAT_BASE 12'h140
`define OC_PPS_SHIFT 12'h180
`define OC_FILT_CTRL 12'h184
`define OC_CTRL_SEL_LSB 0
`define OC_CTRL_SRC0_LSB 4
`define OC_CTRL_SRC0_EN 8
`define OC_CTRL_SRC1_LSB 12
`define OC_CTRL_SRC1_EN 16
`define OC_CTRL_FOLLOW 20
`define OC_CTRL_COMBO 21
`define OC_CTRL_RESET 32'h00000000
`define OC_PPS_HALF_NS 32'd500000000
`define OC_CLK_HZ 100000000
`endif

// ---- dpll_phase_offset_combiner.v ----
// Per-channel phase offset combiner with combo mode steering, reached over APB.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "offset_combiner_map.vh"
module dpll_phase_offset_combiner #(
  parameter NUM_IN = 4,
  parameter NUM_CH = 2,
  parameter OW = 32,
  parameter SW = 34
) (
  input wire CLK, // System clock, 100 MHz.
  input wire RSTN, // Asynchronous reset, active low.
  input wire PSEL, // APB select.
  input wire PENABLE, // APB access phase.
  input wire PWRITE, // APB write when high.
  input wire [11:0] PADDR, // APB byte address.
  input wire [31:0] PWDATA, // APB write data.
  output reg [31:0] PRDATA, // APB read data.
  output reg PREADY, // APB ready.
  output reg PSLVERR, // APB error on unmapped address.
  input wire [NUM_CH*2-1:0] ACTIVE_SEL, // Active input index per channel.
  input wire [NUM_CH*OW-1:0] PHASE_ERR, // Measured phase error per channel.
  input wire [NUM_CH-1:0] PD_UPDATE, // Detector update strobe per channel.
  input wire [NUM_CH-1:0] QL_OK, // Received quality level acceptable per channel.
  output reg [NUM_CH*SW-1:0] LF_IN, // Loop filter phase input per channel.
  output reg [NUM_CH-1:0] LF_VALID, // Loop filter input strobe per channel.
  output reg [NUM_CH*SW-1:0] FREQ_STEER, // Frequency steering per channel.
  output reg [31:0] PPS_SHIFT // Pulse-per-second phase shift in ns.
);
  // Sign-extends an offset to the sum width.
  function [SW-1:0] sext;
    input [OW-1:0] v;
    begin
      sext = {{(SW-OW){v[OW-1]}}, v};
    end
  endfunction
  // Arithmetic shift right by three, done by hand because an unsigned operand
  // anywhere in the sum would otherwise turn >>> into a logical shift.
  function [SW-1:0] asr3;
    input [SW-1:0] v;
    begin
      asr3 = {{3{v[SW-1]}}, v[SW-1:3]};
    end
  endfunction
  // Picks one channel's loop filter input as a steering source; the index wraps at the channel count.
  function [SW-1:0] lf_of;
    input [NUM_CH*SW-1:0] bus;
    input [1:0] idx;
    begin
      lf_of = bus[(idx % NUM_CH)*SW +: SW];
    end
  endfunction
  // Clamps a signed shift request to plus or minus half a second.
  function [31:0] clamp_pps;
    input [31:0] v;
    begin
      if (!v[31] && v > `OC_PPS_HALF_NS)
        clamp_pps = `OC_PPS_HALF_NS;
      else if (v[31] && (~v + 32'h00000001) > `OC_PPS_HALF_NS)
        clamp_pps = ~`OC_PPS_HALF_NS + 32'h00000001;
      else
        clamp_pps = v;
    end
  endfunction
  reg [OW-1:0] in_offs_r [0:NUM_IN-1];
  reg [OW-1:0] ch_offs_r [0:NUM_CH-1];
  reg [31:0] ch_ctrl_r [0:NUM_CH-1];
  reg [OW-1:0] ch_freq_r [0:NUM_CH-1];
  reg [SW-1:0] applied_r [0:NUM_CH-1];
  reg [SW-1:0] filt_r [0:NUM_CH-1];
  reg [1:0] sel_r [0:NUM_CH-1];
  reg [NUM_CH-1:0] switch_seen_r;
  reg [1:0] filt_ctrl_r;
  reg [SW-1:0] steer_nxt [0:NUM_CH-1];
  reg [31:0] rdata_nxt;
  reg err_nxt;
  wire wr_en;
  wire rd_en;
  integer i;
  integer j;
  integer k;
  integer m;
  integer n;
  integer p;
  // Writes land at the access edge; read data is captured at the setup edge so it stands through access.
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  // Register writes; one offset word per input, shared by all channels.
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (i = 0; i < NUM_IN; i = i + 1)
        in_offs_r[i] <= {OW{1'b0}};
      for (i = 0; i < NUM_CH; i = i + 1)
      begin
        ch_offs_r[i] <= {OW{1'b0}};
        ch_ctrl_r[i] <= `OC_CTRL_RESET;
        ch_freq_r[i] <= {OW{1'b0}};
      end
      PPS_SHIFT <= 32'h00000000;
      filt_ctrl_r <= 2'h0;
    end
    else if (wr_en)
    begin
      for (i = 0; i < NUM_IN; i = i + 1)
        if (PADDR == `OC_IN_OFFS_BASE + 4 * i)
          in_offs_r[i] <= PWDATA[OW-1:0];
      for (i = 0; i < NUM_CH; i = i + 1)
      begin
        if (PADDR == `OC_CH_OFFS_BASE + 4 * i)
          ch_offs_r[i] <= PWDATA[OW-1:0];
        if (PADDR == `OC_CH_CTRL_BASE + 4 * i)
          ch_ctrl_r[i] <= PWDATA;
        if (PADDR == `OC_CH_FREQ_BASE + 4 * i)
          ch_freq_r[i] <= PWDATA[OW-1:0];
      end
      // Out-of-range shift requests are clamped rather than refused.
      if (PADDR == `OC_PPS_SHIFT)
        PPS_SHIFT <= clamp_pps(PWDATA);
      // Only the two transient handling bits are kept.
      if (PADDR == `OC_FILT_CTRL)
        filt_ctrl_r <= PWDATA[1:0];
    end
  end
  // Offset sum per channel, recomputed every cycle so a switchover takes the new input at once.
  // The index is read straight off the pins, so a sum after a switch never mixes old and new inputs.
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (k = 0; k < NUM_CH; k = k + 1)
      begin
        applied_r[k] <= {SW{1'b0}};
        sel_r[k] <= 2'h0;
      end
      switch_seen_r <= {NUM_CH{1'b0}};
    end
    else
    begin
      for (k = 0; k < NUM_CH; k = k + 1)
      begin
        // A shared input is read from the single word that every channel sees.
        sel_r[k] <= ACTIVE_SEL[k*2 +: 2];
        switch_seen_r[k] <= (sel_r[k] != ACTIVE_SEL[k*2 +: 2]);
        applied_r[k] <= sext(in_offs_r[ACTIVE_SEL[k*2 +: 2] % NUM_IN]) + sext(ch_offs_r[k]);
      end
    end
  end
  // Loop filter input: phase error plus offset, treated as a detector error.
  // Suppression reloads the smoothing state, so smoothing restarts from the offset alone.
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LF_IN <= {NUM_CH*SW{1'b0}};
      LF_VALID <= {NUM_CH{1'b0}};
      for (m = 0; m < NUM_CH; m = m + 1)
        filt_r[m] <= {SW{1'b0}};
    end
    else
    begin
      for (m = 0; m < NUM_CH; m = m + 1)
      begin
        LF_VALID[m] <= PD_UPDATE[m];
        if (PD_UPDATE[m])
        begin
          // Transient handling: bit 0 smooths, bit 1 drops the error when quality is low.
          if (filt_ctrl_r[1] && !QL_OK[m])
          begin
            filt_r[m] <= applied_r[m];
            LF_IN[m*SW +: SW] <= applied_r[m];
          end
          else if (filt_ctrl_r[0])
          begin
            // One eighth of the distance to the new target per update; the output lags by one update.
            filt_r[m] <= filt_r[m] + asr3(sext(PHASE_ERR[m*OW +: OW]) + applied_r[m] - filt_r[m]);
            LF_IN[m*SW +: SW] <= filt_r[m];
          end
          else
            LF_IN[m*SW +: SW] <= sext(PHASE_ERR[m*OW +: OW]) + applied_r[m];
        end
      end
    end
  end
  // Combo steering: follow mode takes one source channel's loop input alone; otherwise the software frequency word plus up to two source channels' loop inputs.
  always @*
  begin
    for (n = 0; n < NUM_CH; n = n + 1)
    begin
      steer_nxt[n] = sext(ch_freq_r[n]);
      if (ch_ctrl_r[n][`OC_CTRL_COMBO])
      begin
        if (ch_ctrl_r[n][`OC_CTRL_FOLLOW])
          steer_nxt[n] = lf_of(LF_IN, ch_ctrl_r[n][`OC_CTRL_SEL_LSB +: 2]);
        else
        begin
          if (ch_ctrl_r[n][`OC_CTRL_SRC0_EN])
            steer_nxt[n] = steer_nxt[n] + lf_of(LF_IN, ch_ctrl_r[n][`OC_CTRL_SRC0_LSB +: 2]);
          if (ch_ctrl_r[n][`OC_CTRL_SRC1_EN])
            steer_nxt[n] = steer_nxt[n] + lf_of(LF_IN, ch_ctrl_r[n][`OC_CTRL_SRC1_LSB +: 2]);
        end
      end
    end
  end
  // Steering is registered; outside follow mode a software frequency write steps it directly, and combo mode adds loop filter inputs on top.
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      FREQ_STEER <= {NUM_CH*SW{1'b0}};
    else
    begin
      for (p = 0; p < NUM_CH; p = p + 1)
        FREQ_STEER[p*SW +: SW] <= steer_nxt[p];
    end
  end
  // Read decode; unmapped addresses answer with an error.
  always @*
  begin
    rdata_nxt = 32'h00000000;
    err_nxt = 1'b1;
    // Every match clears the error flag; the address ranges never overlap.
    for (j = 0; j < NUM_IN; j = j + 1)
      if (PADDR == `OC_IN_OFFS_BASE + 4 * j)
      begin
        rdata_nxt = in_offs_r[j];
        err_nxt = 1'b0;
      end
    for (j = 0; j < NUM_CH; j = j + 1)
    begin
      if (PADDR == `OC_CH_OFFS_BASE + 4 * j)
      begin
        rdata_nxt = ch_offs_r[j];
        err_nxt = 1'b0;
      end
      if (PADDR == `OC_CH_CTRL_BASE + 4 * j)
      begin
        rdata_nxt = ch_ctrl_r[j];
        err_nxt = 1'b0;
      end
      if (PADDR == `OC_CH_FREQ_BASE + 4 * j)
      begin
        rdata_nxt = ch_freq_r[j];
        err_nxt = 1'b0;
      end
      if (PADDR == `OC_CH_LFIN_BASE + 4 * j)
      begin
        rdata_nxt = applied_r[j][31:0];
        err_nxt = 1'b0;
      end
      if (PADDR == `OC_CH_STAT_BASE + 4 * j)
      begin
        rdata_nxt = {29'h0, switch_seen_r[j], sel_r[j]};
        err_nxt = 1'b0;
      end
    end
    if (PADDR == `OC_PPS_SHIFT)
    begin
      rdata_nxt = PPS_SHIFT;
      err_nxt = 1'b0;
    end
    if (PADDR == `OC_FILT_CTRL)
    begin
      rdata_nxt = {30'h0, filt_ctrl_r};
      err_nxt = 1'b0;
    end
  end
  // APB answer: ready in the access phase, zero wait states.
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && err_nxt;
      // Read data is latched once per transfer and holds until the next read.
      if (rd_en)
        PRDATA <= rdata_nxt;
    end
  end
endmodule // dpll_phase_offset_combiner

// ---- offset_combiner_chk_props.sv ----
// Port assertions for the phase offset combiner.
`timescale 1ns/1ps
module offset_combiner_chk #(parameter NUM_CH = 2, parameter SW = 34) (
  input wire CLK, // Clock.
  input wire RSTN, // Reset, active low.
  input wire PSEL, // Select.
  input wire PENABLE, // Access phase.
  input wire PWRITE, // Direction.
  input wire [31:0] PRDATA, // Read data.
  input wire PREADY, // Ready.
  input wire PSLVERR, // Error.
  input wire [NUM_CH-1:0] PD_UPDATE, // Detector strobe.
  input wire [NUM_CH-1:0] LF_VALID, // Filter strobe.
  input wire [NUM_CH*SW-1:0] LF_IN, // Filter input.
  input wire [31:0] PPS_SHIFT // Pulse shift.
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Filter strobes follow detector updates by exactly one cycle.
  lf_strobe_a: assert property (PD_UPDATE[0] |=> LF_VALID[0]) else $error("strobe 0 missing");
  ch1_strobe_a: assert property (PD_UPDATE[1] |=> LF_VALID[1]) else $error("strobe 1 missing");
  lf_cause_a: assert property (LF_VALID[0] |-> $past(PD_UPDATE[0])) else $error("stray strobe");
  lf_hold_a: assert property (!LF_VALID[0] |-> $stable(LF_IN[SW-1:0])) else $error("input moved");
  // Bus answers come one cycle after setup, for one cycle only.
  ready_setup_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("late ready");
  ready_once_a: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY) else $error("long ready");
  err_zero_a: assert property (PSLVERR && !PWRITE |-> PREADY && PRDATA == 0) else $error("bad error read");
  pps_range_a: assert property ($signed(PPS_SHIFT) <= 500000000 &&
    $signed(PPS_SHIFT) >= -500000000) else $error("shift out of range");
endmodule // offset_combiner_chk
bind dpll_phase_offset_combiner offset_combiner_chk #(.NUM_CH(NUM_CH), .SW(SW)) chk_u (.CLK(CLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PD_UPDATE(PD_UPDATE), .LF_VALID(LF_VALID), .LF_IN(LF_IN), .PPS_SHIFT(PPS_SHIFT));

// ---- phase_detector_model.sv ----
// Phase detector model that issues error samples and update strobes.
`timescale 1ns/1ps
module phase_detector_model #(parameter NUM_CH = 2, parameter OW = 32) (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic [NUM_CH-1:0] trig, // Sample request per channel.
  input wire logic [OW-1:0] err, // Error to present.
  output logic [NUM_CH*OW-1:0] phase_err, // Held error per channel.
  output logic [NUM_CH-1:0] upd // Update pulse.
);
  // Errors hold as levels; the strobe lasts one cycle.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_err <= '0;
      upd <= '0;
    end
    else
    begin
      upd <= trig;
      for (int i = 0; i < NUM_CH; i++)
        if (trig[i])
          phase_err[i*OW+:OW] <= err;
    end
  end
endmodule // phase_detector_model

// ---- test_dpll_phase_offset_combiner.sv ----
// Self-checking testbench for the phase offset combiner.
`timescale 1ns/1ps
module test_dpll_phase_offset_combiner;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, PPS_SHIFT, terr = '0, r;
  logic [31:0] io [4];
  logic [31:0] co [2];
  logic [3:0] ACTIVE_SEL = '0;
  logic [63:0] PHASE_ERR;
  logic [1:0] PD_UPDATE, LF_VALID, QL_OK = 2'h3, trig = '0;
  logic [67:0] LF_IN, FREQ_STEER;
  logic [32:0] rq [$];
  logic [32:0] rn;
  logic [33:0] lq [$];
  logic [33:0] fs [2] = '{34'h0, 34'h0};
  logic [33:0] lf_last [2];
  logic [31:0] fw [2];
  logic [1:0] fc = 2'h0;
  int miscompares = 0, n_checks = 0;
  dpll_phase_offset_combiner dut_u (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ACTIVE_SEL(ACTIVE_SEL),
    .PHASE_ERR(PHASE_ERR), .PD_UPDATE(PD_UPDATE), .QL_OK(QL_OK), .LF_IN(LF_IN), .LF_VALID(LF_VALID),
    .FREQ_STEER(FREQ_STEER), .PPS_SHIFT(PPS_SHIFT));
  phase_detector_model det_u (.clk(CLK), .rst_n(RSTN), .trig(trig), .err(terr), .phase_err(PHASE_ERR),
    .upd(PD_UPDATE));
  always #5 CLK = ~CLK;
  function logic [33:0] sx(input logic [31:0] v);
    return {{2{v[31]}}, v};
  endfunction
  task cmp(input string nm, input logic [33:0] ex, input logic [33:0] got);
    n_checks++;
    if (got !== ex)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One bus transfer: setup, then access held until ready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    @(posedge CLK iff PREADY === 1'b1);
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] ex, input logic er);
    rq.push_back({er, ex});
    apb(0, a, 32'h0);
  endtask
  // One detector update; the expected filter input is noted first.
  // Suppression keeps only the offset; smoothing moves one eighth of the way and shows the old state.
  task pd(input int c, input logic [31:0] e);
    logic [33:0] a, t, ex;
    logic [1:0] q;
    a = sx(io[ACTIVE_SEL[2*c+:2]]) + sx(co[c]);
    t = sx(e) + a;
    q = 2'($urandom);
    if (fc[1] && !q[c])
    begin
      ex = a;
      fs[c] = a;
    end
    else if (fc[0])
    begin
      ex = fs[c];
      t = t - fs[c];
      fs[c] = fs[c] + {{3{t[33]}}, t[33:3]};
    end
    else
      ex = t;
    lq.push_back(ex);
    lf_last[c] = ex;
    QL_OK <= q;
    terr <= e;
    trig <= 2'(1 << c);
    @(posedge CLK);
    trig <= 2'h0;
    repeat (4) @(posedge CLK);
  endtask
  // Results are compared in arrival order.
  always @(posedge CLK)
  begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
    begin
      rn = rq.pop_front();
      cmp("prdata", 34'(rn[31:0]), 34'(PRDATA));
      cmp("pslverr", 34'(rn[32]), 34'(PSLVERR));
    end
    for (int c = 0; c < 2; c++)
      if (LF_VALID[c] === 1'b1)
        cmp("lf_in", lq.pop_front(), LF_IN[c*34+:34]);
  end
  initial
  begin
    #400000;
    miscompares++;
    close_out;
  end
  initial
  begin
    r = $urandom(32'hd57a);
    repeat (12) @(posedge CLK);
    RSTN <= 1;
    for (int i = 0; i < 4; i++)
    begin
      io[i] = $urandom;
      apb(1, 12'(4 * i), io[i]);
    end
    for (int c = 0; c < 2; c++)
    begin
      co[c] = $urandom;
      apb(1, 12'(12'h040 + 4 * c), co[c]);
    end
    rd(12'h008, io[2], 0);
    rd(12'h044, co[1], 0);
    // Every channel walks through every input, sharing the input offsets.
    for (int c = 0; c < 2; c++)
      for (int s = 0; s < 4; s++)
      begin
        ACTIVE_SEL[2*c+:2] <= 2'(s);
        repeat (3) @(posedge CLK);
        pd(c, $urandom);
      end
    rd(12'h100, 32'(sx(io[3]) + sx(co[0])), 0);
    rd(12'h144, 32'h3, 0);
    // Extreme sums must not wrap.
    for (int k = 0; k < 2; k++)
    begin
      io[3] = k ? 32'h80000000 : 32'h7fffffff;
      co[0] = io[3];
      apb(1, 12'h00c, io[3]);
      apb(1, 12'h040, co[0]);
      pd(0, io[3]);
    end
    // Transient handling: smoothing, suppression on poor quality, then both.
    for (int f = 1; f < 4; f++)
    begin
      fc = 2'(f);
      apb(1, 12'h184, 32'(fc));
      repeat (3)
        for (int c = 0; c < 2; c++)
          pd(c, $urandom);
    end
    fc = 2'h0;
    apb(1, 12'h184, 32'h0);
    // Plain steering is the software word; combo follows or adds loop filter inputs on top of it.
    for (int c = 0; c < 2; c++)
    begin
      fw[c] = $urandom;
      apb(1, 12'(12'h0c0 + 4 * c), fw[c]);
    end
    repeat (2) @(posedge CLK);
    for (int c = 0; c < 2; c++)
      cmp("freq_steer", sx(fw[c]), FREQ_STEER[c*34+:34]);
    apb(1, 12'h084, 32'h00300000);
    pd(0, $urandom);
    cmp("freq_steer", lf_last[0], FREQ_STEER[34+:34]);
    apb(1, 12'h084, 32'h00211100);
    pd(1, $urandom);
    pd(0, $urandom);
    cmp("freq_steer", sx(fw[1]) + lf_last[0] + lf_last[1], FREQ_STEER[34+:34]);
    cmp("freq_steer", sx(fw[0]), FREQ_STEER[0+:34]);
    apb(1, 12'h084, 32'h0);
    rd(12'h1fc, 32'h0, 1);
    apb(1, 12'h180, 32'h23c34600);
    rd(12'h180, 32'h1dcd6500, 0);
    apb(1, 12'h180, 32'hdc3cba00);
    rd(12'h180, 32'he2329b00, 0);
    cmp("pps", 34'(32'he2329b00), 34'(PPS_SHIFT));
    repeat (4) @(posedge CLK);
    close_out;
  end
endmodule // test_dpll_phase_offset_combiner
